// File: design/iosg_fifo.sv
// small word fifo with registered read data
`timescale 1ns/10ps
module iosg_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic                       clk_sys,
	input  wire logic                       nrst,
	// streams
	iosg_stream_if.snk                      wr,
	iosg_stream_if.src                      rd,
	// fill level
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int AW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem_r [DEPTH];
	logic [W-1:0]  mem_nxt [DEPTH];
	logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
	logic [LW-1:0] cnt_r, cnt_nxt;
	logic [W-1:0]  dout_r, dout_nxt;
	logic          dval_r, dval_nxt;
	logic          push, pop;

	// pointers wrap naturally, so depth must be a power of two
	always_comb begin
		mem_nxt  = mem_r;
		wptr_nxt = wptr_r;
		rptr_nxt = rptr_r;
		dout_nxt = dout_r;
		dval_nxt = dval_r;
		push     = wr.valid && (cnt_r != LW'(DEPTH));
		pop      = (cnt_r != '0) && (!dval_r || rd.ready);
		if (rd.ready && dval_r)
			dval_nxt = 1'b0;
		if (pop) begin
			dout_nxt = mem_r[rptr_r];
			dval_nxt = 1'b1;
			rptr_nxt = rptr_r + 1'b1;
		end
		if (push) begin
			mem_nxt[wptr_r] = wr.data;
			wptr_nxt        = wptr_r + 1'b1;
		end
		cnt_nxt = cnt_r + LW'(push) - LW'(pop);
	end

	always_ff @(posedge clk_sys) begin
		mem_r <= mem_nxt;
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r  <= '0;
			dout_r <= '0;
			dval_r <= 1'b0;
		end else begin
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
			cnt_r  <= cnt_nxt;
			dout_r <= dout_nxt;
			dval_r <= dval_nxt;
		end
	end

	assign wr.ready = (cnt_r != LW'(DEPTH));
	assign rd.data  = dout_r;
	assign rd.valid = dval_r;
	assign level    = cnt_r;
endmodule : iosg_fifo

// File: design/iosg_params.svh
// offsets, field positions, reset values and timing counts of the gearbox
`ifndef IOSG_PARAMS_SVH
`define IOSG_PARAMS_SVH
`define IOSG_OFS_CTRL      4'h0
`define IOSG_OFS_DELAY     4'h4
`define IOSG_OFS_STATUS    4'h8
`define IOSG_OFS_ALIGN     4'hc
`define IOSG_CTRL_RXMODE   0
`define IOSG_CTRL_TXMODE   2
`define IOSG_CTRL_RXEN     4
`define IOSG_CTRL_TXEN     5
`define IOSG_STAT_OVF      0
`define IOSG_STAT_UNDR     1
`define IOSG_STAT_LEVEL    4
`define IOSG_CTRL_RST      6'h00
`define IOSG_DELAY_RST     3'h0
`define IOSG_ALIGN_RST     16'h0000
`define IOSG_DELAY_TAPS    8
`define IOSG_FIFO_DEPTH    8
`define IOSG_CLK_PERIOD_NS 4
`define IOSG_LINK_PERIOD_NS 32
`define IOSG_EDGE_CYCLES   ((`IOSG_LINK_PERIOD_NS / 2) / `IOSG_CLK_PERIOD_NS)
`endif

// File: design/iosg_pkg.sv
// types and mode decoding shared by the gearbox files
package iosg_pkg;
	typedef enum logic [1:0] {
		mode_video7,
		mode_ddr8,
		mode_dual4
	} iosg_mode_t;

	// index of the last bit of a word in the given mode
	function automatic logic [2:0] iosg_last(input logic [1:0] m);
		logic [2:0] r;
		r = 3'h7;
		unique case (m)
			2'h0: r = 3'h6;
			2'h1: r = 3'h7;
			2'h2: r = 3'h3;
			default: r = 3'h7;
		endcase
		return r;
	endfunction : iosg_last

	function automatic iosg_mode_t iosg_mode(input logic [1:0] m);
		iosg_mode_t r;
		r = mode_ddr8;
		if (m == 2'h0)
			r = mode_video7;
		else if (m == 2'h2)
			r = mode_dual4;
		return r;
	endfunction : iosg_mode
endpackage : iosg_pkg

// File: design/iosg_stream_if.sv
// valid/ready word stream between gearbox modules
`timescale 1ns/10ps
interface iosg_stream_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : iosg_stream_if

// File: design/iosg_sync.sv
// two-flop synchroniser for pin and link clock inputs
`timescale 1ns/10ps
module iosg_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	// asynchronous in, synchronised out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk_sys) begin
				if (!nrst) begin
					s1_r[i] <= 1'b0;
					s2_r[i] <= 1'b0;
				end else begin
					s1_r[i] <= d[i];
					s2_r[i] <= s1_r[i];
				end
			end
		end
	endgenerate
	assign q = s2_r;
endmodule : iosg_sync

// File: design/iosg_top.sv
// serial/parallel gearbox pair with avalon control registers
//
// The Avalon-MM register port and the register offsets were decided locally.
`include "iosg_params.svh"
`timescale 1ns/10ps
module iosg_top (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// serial link
	input  wire logic        fast_edge_clock,
	input  wire logic [1:0]  rx_serial,
	output logic      [1:0]  tx_serial,
	// core receive side
	input  wire logic        word_align_request,
	output logic             align_select,
	output logic      [7:0]  rx_q,
	output logic             rx_q_valid,
	input  wire logic        rx_q_ready,
	// core transmit side
	input  wire logic [7:0]  tx_d,
	input  wire logic        tx_d_valid,
	output logic             tx_d_ready
);
	localparam int DW = `IOSG_DELAY_TAPS - 1;
	localparam int LW = $clog2(`IOSG_FIFO_DEPTH + 1);

	// register group
	logic [5:0]    ctrl_r, ctrl_nxt;
	logic [2:0]    delay_r, delay_nxt;
	logic          ovf_r, ovf_nxt, undr_r, undr_nxt;
	logic [15:0]   align_cnt_r, align_cnt_nxt;
	logic          waitreq_r, waitreq_nxt;
	logic [31:0]   rdata_r, rdata_nxt;
	logic [LW-1:0] fifo_level;
	logic          wr_go, rd_go;
	// receive group
	logic [2:0]    sync_q;
	logic          lclk_s, lclk_d_r, lclk_d_nxt, link_edge;
	logic [1:0]    din;
	logic [DW-1:0] dly_r [2];
	logic [DW-1:0] dly_nxt [2];
	logic [1:0]    tap;
	logic [1:0]    cap_r, cap_nxt;
	logic          cap_vld_r, cap_vld_nxt;
	logic [2:0]    rcnt_r, rcnt_nxt;
	logic [7:0]    rsh_a_r, rsh_a_nxt;
	logic [3:0]    rsh_c_r, rsh_c_nxt;
	logic          slip_r, slip_nxt, req_d_r, req_d_nxt, req_rise;
	logic [7:0]    rxw_r, rxw_nxt;
	logic          rxw_vld_r, rxw_vld_nxt;
	logic          rupd, ovf_set;
	logic          rx_en, tx_en;
	iosg_pkg::iosg_mode_t rx_mode, tx_mode;
	// transmit group
	logic [7:0]    hold_r, hold_nxt;
	logic          hold_full_r, hold_full_nxt;
	logic          tx_rdy_r, tx_rdy_nxt;
	logic [2:0]    tcnt_r, tcnt_nxt;
	logic [7:0]    tsh_r, tsh_nxt, tword;
	logic [1:0]    tpin_r, tpin_nxt;
	logic          undr_set;

	iosg_stream_if #(.W(8)) fifo_in ();
	iosg_stream_if #(.W(8)) fifo_out ();

	// one decoder for both read and write paths
	function automatic logic reg_hit(input logic [3:0] a,
	                                 input logic [3:0] ofs);
		return a == ofs;
	endfunction : reg_hit

	iosg_sync #(.W(3)) u_sync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.d       ({rx_serial, fast_edge_clock}),
		.q       (sync_q)
	);

	iosg_fifo #(.W(8), .DEPTH(`IOSG_FIFO_DEPTH)) u_fifo (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.wr      (fifo_in),
		.rd      (fifo_out),
		.level   (fifo_level)
	);

	assign lclk_s  = sync_q[0];
	assign din     = sync_q[2:1];
	assign rx_en   = ctrl_r[`IOSG_CTRL_RXEN];
	assign tx_en   = ctrl_r[`IOSG_CTRL_TXEN];
	assign rx_mode = iosg_pkg::iosg_mode(ctrl_r[`IOSG_CTRL_RXMODE +: 2]);
	assign tx_mode = iosg_pkg::iosg_mode(ctrl_r[`IOSG_CTRL_TXMODE +: 2]);

	// avalon slave: one wait cycle, then a single-cycle answer
	always_comb begin
		ctrl_nxt    = ctrl_r;
		delay_nxt   = delay_r;
		rdata_nxt   = rdata_r;
		wr_go       = avs_write && !waitreq_r;
		rd_go       = avs_read && waitreq_r;
		waitreq_nxt = !((avs_read || avs_write) && waitreq_r);
		ovf_nxt     = ovf_r;
		undr_nxt    = undr_r;
		if (wr_go && reg_hit(avs_address, `IOSG_OFS_CTRL))
			ctrl_nxt = avs_writedata[5:0];
		if (wr_go && reg_hit(avs_address, `IOSG_OFS_DELAY))
			delay_nxt = avs_writedata[2:0];
		if (wr_go && reg_hit(avs_address, `IOSG_OFS_STATUS)) begin
			if (avs_writedata[`IOSG_STAT_OVF])
				ovf_nxt = 1'b0;
			if (avs_writedata[`IOSG_STAT_UNDR])
				undr_nxt = 1'b0;
		end
		// set after clear so a same-cycle event is kept
		if (ovf_set)
			ovf_nxt = 1'b1;
		if (undr_set)
			undr_nxt = 1'b1;
		if (rd_go) begin
			rdata_nxt = 32'h0000_0000;
			if (reg_hit(avs_address, `IOSG_OFS_CTRL))
				rdata_nxt[5:0] = ctrl_r;
			else if (reg_hit(avs_address, `IOSG_OFS_DELAY))
				rdata_nxt[2:0] = delay_r;
			else if (reg_hit(avs_address, `IOSG_OFS_STATUS)) begin
				rdata_nxt[`IOSG_STAT_OVF]            = ovf_r;
				rdata_nxt[`IOSG_STAT_UNDR]           = undr_r;
				rdata_nxt[`IOSG_STAT_LEVEL +: LW]    = fifo_level;
			end else if (reg_hit(avs_address, `IOSG_OFS_ALIGN))
				rdata_nxt[15:0] = align_cnt_r;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ctrl_r    <= `IOSG_CTRL_RST;
			delay_r   <= `IOSG_DELAY_RST;
			ovf_r     <= 1'b0;
			undr_r    <= 1'b0;
			waitreq_r <= 1'b1;
			rdata_r   <= 32'h0000_0000;
		end else begin
			ctrl_r    <= ctrl_nxt;
			delay_r   <= delay_nxt;
			ovf_r     <= ovf_nxt;
			undr_r    <= undr_nxt;
			waitreq_r <= waitreq_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	// receive: delay taps, edge capture, assembly, output word
	always_comb begin
		lclk_d_nxt    = lclk_s;
		link_edge     = lclk_s ^ lclk_d_r;
		req_d_nxt     = word_align_request;
		req_rise      = word_align_request && !req_d_r;
		for (int l = 0; l < 2; l++) begin
			dly_nxt[l] = {dly_r[l][DW-2:0], din[l]};
			tap[l]     = (delay_r == 3'h0) ? din[l]
			           : dly_r[l][delay_r - 3'h1];
		end
		cap_nxt       = link_edge ? tap : cap_r;
		cap_vld_nxt   = link_edge && rx_en;
		rcnt_nxt      = rcnt_r;
		rsh_a_nxt     = rsh_a_r;
		rsh_c_nxt     = rsh_c_r;
		slip_nxt      = slip_r || req_rise;
		align_cnt_nxt = align_cnt_r;
		rupd          = 1'b0;
		if (!rx_en) begin
			rcnt_nxt = 3'h0;
			slip_nxt = 1'b0;
		end else if (cap_vld_r) begin
			if (slip_r) begin
				// drop one bit to move the word boundary
				slip_nxt      = req_rise;
				align_cnt_nxt = align_cnt_r + 16'h0001;
			end else begin
				rsh_a_nxt[rcnt_r]      = cap_r[0];
				rsh_c_nxt[rcnt_r[1:0]] = cap_r[1];
				if (rcnt_r == iosg_pkg::iosg_last(rx_mode)) begin
					rcnt_nxt = 3'h0;
					rupd     = 1'b1;
				end else
					rcnt_nxt = rcnt_r + 3'h1;
			end
		end
		rxw_nxt = rxw_r;
		unique case (rx_mode)
			iosg_pkg::mode_video7: rxw_nxt = {1'b0, rsh_a_nxt[6:0]};
			iosg_pkg::mode_ddr8:   rxw_nxt = rsh_a_nxt;
			iosg_pkg::mode_dual4:  rxw_nxt = {rsh_a_nxt[3:0], rsh_c_nxt};
		endcase
		if (!rupd)
			rxw_nxt = rxw_r;
		rxw_vld_nxt = rupd;
		// the serial link cannot stall, so a full fifo drops the word
		ovf_set = rxw_vld_r && !fifo_in.ready;
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			lclk_d_r    <= 1'b0;
			dly_r[0]    <= '0;
			dly_r[1]    <= '0;
			cap_r       <= 2'h0;
			cap_vld_r   <= 1'b0;
			rcnt_r      <= 3'h0;
			rsh_a_r     <= 8'h00;
			rsh_c_r     <= 4'h0;
			slip_r      <= 1'b0;
			req_d_r     <= 1'b0;
			align_cnt_r <= `IOSG_ALIGN_RST;
			rxw_r       <= 8'h00;
			rxw_vld_r   <= 1'b0;
		end else begin
			lclk_d_r    <= lclk_d_nxt;
			dly_r       <= dly_nxt;
			cap_r       <= cap_nxt;
			cap_vld_r   <= cap_vld_nxt;
			rcnt_r      <= rcnt_nxt;
			rsh_a_r     <= rsh_a_nxt;
			rsh_c_r     <= rsh_c_nxt;
			slip_r      <= slip_nxt;
			req_d_r     <= req_d_nxt;
			align_cnt_r <= align_cnt_nxt;
			rxw_r       <= rxw_nxt;
			rxw_vld_r   <= rxw_vld_nxt;
		end
	end

	assign fifo_in.data   = rxw_r;
	assign fifo_in.valid  = rxw_vld_r;
	assign fifo_out.ready = rx_q_ready;

	// transmit: hold register, boundary load, per-edge shift
	always_comb begin
		hold_nxt      = hold_r;
		hold_full_nxt = hold_full_r;
		tcnt_nxt      = tcnt_r;
		tsh_nxt       = tsh_r;
		tpin_nxt      = tpin_r;
		undr_set      = 1'b0;
		tword         = tsh_r;
		if (tx_d_valid && tx_rdy_r) begin
			hold_nxt      = tx_d;
			hold_full_nxt = 1'b1;
		end
		if (!tx_en) begin
			tcnt_nxt = 3'h0;
			tpin_nxt = 2'h0;
		end else if (link_edge) begin
			if (tcnt_r == 3'h0) begin
				// an empty hold at the boundary sends zeros
				tword         = hold_full_r ? hold_r : 8'h00;
				undr_set      = !hold_full_r;
				tsh_nxt       = tword;
				hold_full_nxt = tx_d_valid && tx_rdy_r;
			end
			unique case (tx_mode)
				iosg_pkg::mode_video7,
				iosg_pkg::mode_ddr8:  tpin_nxt = {1'b0, tword[tcnt_r]};
				iosg_pkg::mode_dual4: tpin_nxt = {tword[3'h4 + tcnt_r],
				                                  tword[tcnt_r]};
			endcase
			if (tcnt_r == iosg_pkg::iosg_last(tx_mode))
				tcnt_nxt = 3'h0;
			else
				tcnt_nxt = tcnt_r + 3'h1;
		end
		tx_rdy_nxt = !hold_full_nxt;
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			hold_r      <= 8'h00;
			hold_full_r <= 1'b0;
			tx_rdy_r    <= 1'b0;
			tcnt_r      <= 3'h0;
			tsh_r       <= 8'h00;
			tpin_r      <= 2'h0;
		end else begin
			hold_r      <= hold_nxt;
			hold_full_r <= hold_full_nxt;
			tx_rdy_r    <= tx_rdy_nxt;
			tcnt_r      <= tcnt_nxt;
			tsh_r       <= tsh_nxt;
			tpin_r      <= tpin_nxt;
		end
	end

	assign avs_readdata    = rdata_r;
	assign avs_waitrequest = waitreq_r;
	assign tx_serial       = tpin_r;
	assign align_select    = slip_r;
	assign rx_q            = fifo_out.data;
	assign rx_q_valid      = fifo_out.valid;
	assign tx_d_ready      = tx_rdy_r;
endmodule : iosg_top

// File: sim/iosg_chk_assertions.sv
// port-level assertions for the gearbox top
`timescale 1ns/10ps
module iosg_chk (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        nrst,
	// register bus
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// link and core
	input wire logic [1:0]  tx_serial,
	input wire logic        word_align_request,
	input wire logic        align_select,
	input wire logic [7:0]  rx_q,
	input wire logic        rx_q_valid,
	input wire logic        rx_q_ready,
	input wire logic        tx_d_valid,
	input wire logic        tx_d_ready
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	rst_clear_a: assert property ($rose(nrst) |-> avs_waitrequest
		&& !rx_q_valid && !align_select && tx_serial == 2'h0 && !tx_d_ready)
		else $error("outputs not cleared by reset");
	ack_next_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("bus answer late");
	ack_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer longer than one cycle");
	unmapped_zero_a: assert property (avs_read && avs_waitrequest
		&& avs_address[1:0] != 2'h0 |=> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	ctrl_upper_a: assert property (avs_read && avs_waitrequest
		&& avs_address == 4'h0 |=> avs_readdata[31:6] == 26'h0)
		else $error("control upper bits not zero");
	rxq_hold_a: assert property (rx_q_valid && !rx_q_ready
		|=> rx_q_valid && $stable(rx_q)) else $error("rx word not held");
	// a word boundary in the take cycle still leaves the new word in the hold
	tx_take_a: assert property (tx_d_valid && tx_d_ready
		|=> !tx_d_ready) else $error("tx ready not dropped");
	slip_flag_a: assert property ($rose(word_align_request)
		|-> ##[1:2] align_select) else $error("slip not flagged");
endmodule : iosg_chk

bind iosg_top iosg_chk i_chk (.clk_sys, .nrst, .avs_address, .avs_read,
	.avs_write, .avs_readdata, .avs_waitrequest, .tx_serial,
	.word_align_request, .align_select, .rx_q, .rx_q_valid, .rx_q_ready,
	.tx_d_valid, .tx_d_ready);

// File: sim/iosg_link_model.sv
// far-side serial link: link clock, rx bits, tx pin capture
`timescale 1ns/10ps
module iosg_link_model (
	// link pins
	output logic            fast_edge_clock,
	output logic [1:0]      rx_serial,
	input  wire logic [1:0] tx_serial
);
	logic [1:0] cap [0:31];
	initial begin
		fast_edge_clock = 1'b0;
		rx_serial = 2'h0;
	end
	// one bit per edge, lsb first; 16 ns per edge
	task automatic run(input int n, input logic [31:0] a,
	                   input logic [31:0] c);
		#1;
		for (int i = 0; i < n; i++) begin
			rx_serial = {c[i], a[i]};
			#8;
			fast_edge_clock = ~fast_edge_clock;
			// sampled well clear of the pin's change window
			#6;
			cap[i] = tx_serial;
			#2;
		end
		// clock stands still; released data does not keep its value
		rx_serial = ~rx_serial;
	endtask : run
endmodule : iosg_link_model

// File: sim/tb.sv
// gearbox bench: rx modes, slip, fifo, tx modes, registers, reset
`timescale 1ns/10ps
module tb;
	logic        clk_sys = 1'b0;
	logic        nrst = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        fast_edge_clock;
	logic [1:0]  rx_serial;
	logic [1:0]  tx_serial;
	logic        word_align_request = 1'b0;
	logic        align_select;
	logic [7:0]  rx_q;
	logic        rx_q_valid;
	logic        rx_q_ready = 1'b0;
	logic [7:0]  tx_d = 8'h0;
	logic        tx_d_valid = 1'b0;
	logic        tx_d_ready;
	int          err_total = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	logic [31:0] rd;
	always #2 clk_sys = ~clk_sys;
	iosg_top i_dut (.clk_sys, .nrst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .fast_edge_clock,
		.rx_serial, .tx_serial, .word_align_request, .align_select, .rx_q,
		.rx_q_valid, .rx_q_ready, .tx_d, .tx_d_valid, .tx_d_ready);
	iosg_link_model i_link (.fast_edge_clock, .rx_serial, .tx_serial);
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// one avalon access, held until waitrequest is seen low
	// no limit of its own: a hung wait ends in the bench timeout
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		do
			@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask : bus
	task automatic rx_word(input logic [7:0] e);
		@(posedge clk_sys);
		while (rx_q_valid !== 1'b1)
			@(posedge clk_sys);
		chk("rx_q", {24'h0, e}, {24'h0, rx_q});
		rx_q_ready <= 1'b1;
		@(posedge clk_sys);
		rx_q_ready <= 1'b0;
		@(posedge clk_sys);
	endtask : rx_word
	task automatic scn_rx_modes();
		logic [7:0] a [3];
		logic [7:0] c [3];
		logic [7:0] e [3];
		a = '{8'hd5, 8'hb5, 8'h0b};
		c = '{8'h00, 8'h00, 8'h06};
		e = '{8'h55, 8'hb5, 8'hb6};
		for (int m = 0; m < 3; m++) begin
			bus(1'b1, 4'h0, 32'h0);
			bus(1'b1, 4'h0, 32'h10 | 32'(m));
			i_link.run(m == 2 ? 4 : 7 + m, {24'h0, a[m]}, {24'h0, c[m]});
			rx_word(e[m]);
		end
	endtask : scn_rx_modes
	task automatic scn_slip();
		// one tap still lands inside the stable window of each bit
		bus(1'b1, 4'h4, 32'h1);
		bus(1'b1, 4'h0, 32'h0);
		bus(1'b1, 4'h0, 32'h11);
		word_align_request <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk("align_select", 32'h1, {31'h0, align_select});
		word_align_request <= 1'b0;
		// leading bit is thrown away by the pending slip
		i_link.run(9, 32'h16b, 32'h0);
		rx_word(8'hb5);
		bus(1'b0, 4'hc, 32'h0);
		chk("slip count", 32'h1, rd);
	endtask : scn_slip
	task automatic scn_fifo();
		bus(1'b1, 4'h0, 32'h0);
		bus(1'b1, 4'h0, 32'h11);
		// nine fit: eight in memory plus the head register; tenth drops
		for (int i = 0; i < 10; i++)
			i_link.run(8, 32'h30 + 32'(i), 32'h0);
		repeat (20) @(posedge clk_sys);
		bus(1'b0, 4'h8, 32'h0);
		chk("status full", 32'h81, rd & 32'hf1);
		for (int i = 0; i < 9; i++)
			rx_word(8'h30 + 8'(i));
		bus(1'b1, 4'h8, 32'h1);
		bus(1'b0, 4'h8, 32'h0);
		chk("status drained", 32'h0, rd & 32'hf1);
	endtask : scn_fifo
	function automatic logic [7:0] pick(input int l);
		int f;
		logic [7:0] v;
		f = -1;
		v = 8'h0;
		for (int i = 23; i >= 0; i--)
			if (i_link.cap[i][l] === 1'b1) f = i;
		for (int k = 0; k < 8; k++)
			if (f >= 0 && f + k < 24) v[k] = i_link.cap[f + k][l];
		return v;
	endfunction : pick
	task automatic scn_tx();
		logic [7:0] w [3];
		logic [7:0] e [3];
		w = '{8'hd5, 8'hb5, 8'h9b};
		e = '{8'h55, 8'hb5, 8'h0b};
		for (int m = 0; m < 3; m++) begin
			bus(1'b1, 4'h0, 32'h0);
			bus(1'b1, 4'h0, 32'h20 | 32'(m << 2));
			tx_d <= w[m];
			tx_d_valid <= 1'b1;
			do
				@(posedge clk_sys);
			while (tx_d_ready !== 1'b1);
			tx_d_valid <= 1'b0;
			i_link.run(24, 32'h0, 32'h0);
			@(posedge clk_sys);
			chk("tx lane a", {24'h0, e[m]}, {24'h0, pick(0)});
			chk("tx lane c", m == 2 ? 32'h9 : 32'h0, {24'h0, pick(1)});
		end
		// boundaries after the single word found the hold empty
		bus(1'b0, 4'h8, 32'h0);
		chk("status underrun", 32'h2, rd & 32'h2);
	endtask : scn_tx
	task automatic scn_reset();
		bus(1'b1, 4'h0, 32'h3f);
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl", 32'h3f, rd);
		bus(1'b1, 4'h4, 32'h7);
		bus(1'b0, 4'h4, 32'h0);
		chk("delay", 32'h7, rd);
		bus(1'b1, 4'h6, 32'hffff);
		bus(1'b0, 4'h6, 32'h0);
		chk("unmapped", 32'h0, rd);
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		for (int a = 0; a < 16; a += 4) begin
			bus(1'b0, 4'(a), 32'h0);
			chk("reset value", 32'h0, rd);
		end
	endtask : scn_reset
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	// ceiling well above the thousand or so cycles the scenarios need
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			complete_run();
		end
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		scn_rx_modes();
		scn_slip();
		scn_fifo();
		scn_tx();
		scn_reset();
		complete_run();
	end
endmodule : tb
